// *** logic/ecx_regs.sv ***
// extended register bank of the parallel port: host side and control
`timescale 1ns/1ps
`default_nettype none
`include "ecx_map.svh"

// How it works
// RULE1: capability word fixed 100 and 0001 fields
// RULE2: capability bit 3 mirrors config bit 7
// RULE3: resource report read-only, bits 2,7 zero
// RULE4: resource bits 1,0 mirror DMA channel field
// RULE5: resource bits 5-3 mirror interrupt number field
// RULE6: interrupt field codes jumper, then seven lines
// RULE7: resource bit 6 shows selected IRQ level
// RULE8: mode control resets to 00010xx1; code resets it to 000101xx
// RULE9: stretch mode control reads with IOCHRDY low
// RULE10: empty/full flags live, read 1 frozen
// RULE11: service bit set by events, software clears
// RULE12: DMA terminal count interrupts when armed
// RULE13: thresholds of eight interrupt without DMA
// RULE14: DMA disabled floats request, ignores acknowledge
// RULE15: error edge or unmask interrupts unless masked
// RULE16: bits 7-5 select operating mode
// RULE17: index selects four control registers only
// RULE18: index bits 7-3 read and count zero
// RULE19: indirect pair needs enable, reset-only init
// RULE20: indirect data moves all eight bits
// RULE21: aux status shows FIFO tag in mode 011; code shows it only when dir_backward is also set
// RULE22: control zero bit 0 enables time-out interrupt
// RULE23: direction 0 forward driving, 1 backward
// RULE24: frozen clock input forces readback overrides

module ecx_regs (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // host I/O pins
    input  wire logic        io_sel_n,
    input  wire logic        io_rd_n,
    input  wire logic        io_wr_n,
    input  wire logic [2:0]  io_addr,
    input  wire logic [7:0]  io_data_in,
    output logic      [7:0]  io_data_out,
    output logic             io_data_oe_n,
    output logic             iochrdy_out,
    output logic             iochrdy_oe_n,
    // printer error and selected interrupt line pins
    input  wire logic        err_n,
    input  wire logic        irq_line_level,
    // DMA pins
    input  wire logic        dma_ack_in,
    output logic             dma_req_out,
    output logic             dma_req_oe_n,
    // FIFO and port logic, same clock
    input  wire logic        fifo_empty,
    input  wire logic        fifo_full,
    input  wire logic        fifo_free_ge8,
    input  wire logic        fifo_avail_ge8,
    input  wire logic        fifo_bottom_tag,
    input  wire logic        dma_req_raw,
    input  wire logic        dma_tc,
    input  wire logic        dir_backward,
    input  wire logic        port_clk_frozen,
    input  wire logic        ext_cfg_enable,
    // control outputs
    output logic             ecp_irq,
    output logic             dma_ack_eff,
    output ecx_pkg::ecx_mode_t mode,
    output logic             epp_timeout_irq_en,
    output logic      [7:0]  timeout_irq_control,
    output logic      [7:0]  second_control_reg,
    output logic      [7:0]  dma_fairness_control,
    output logic      [7:0]  port_resource_config
);

    // ---------------------------------------------------------------
    // decoding functions
    // ---------------------------------------------------------------

    // second-level index that names one of the four control registers
    function automatic logic idx_valid(input logic [2:0] idx);
        idx_valid = (idx == `ECX_IDX_CTRL0) || (idx == `ECX_IDX_CTRL2) ||
                    (idx == `ECX_IDX_CTRL4) ||
                    (idx == `ECX_IDX_PPCFG); // see RULE17
    endfunction

    // host offset that this bank answers in the current mode
    function automatic logic addr_ours(input logic [2:0]  a,
                                       input logic [2:0]  m,
                                       input logic        ext);
        logic cfg;
        cfg = (m == ecx_pkg::ECX_MODE_CFG);
        addr_ours = ((a == `ECX_OFF_CAPA) && cfg) ||
                    ((a == `ECX_OFF_RSRC) && cfg) ||
                    (a == `ECX_OFF_EMC) ||
                    (((a == `ECX_OFF_INDEX) || (a == `ECX_OFF_IDATA))
                        && ext) || // see RULE19
                    (a == `ECX_OFF_AUX);
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [`ECX_BUS_SYNC_W-1:0] bus_meta;
    logic [`ECX_BUS_SYNC_W-1:0] bus_sync;
    logic [2:0]                 pin_meta;
    logic [2:0]                 pin_sync;
    logic [`ECX_BUS_SYNC_W-1:0] next_bus_meta;
    logic [`ECX_BUS_SYNC_W-1:0] next_bus_sync;
    logic [2:0]                 next_pin_meta;
    logic [2:0]                 next_pin_sync;

    // two flops on every asynchronous pin
    always_comb
    begin
        next_bus_meta = {io_sel_n, io_rd_n, io_wr_n, io_addr, io_data_in};
        next_bus_sync = bus_meta;
        next_pin_meta = {err_n, irq_line_level, dma_ack_in};
        next_pin_sync = pin_meta;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            bus_meta <= {`ECX_BUS_SYNC_W{1'b1}};
            bus_sync <= {`ECX_BUS_SYNC_W{1'b1}};
            pin_meta <= 3'h6;
            pin_sync <= 3'h6;
        end
        else
        begin
            bus_meta <= next_bus_meta;
            bus_sync <= next_bus_sync;
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
        end
    end

    // synchronised fields
    logic       sel_n_s;
    logic       rd_n_s;
    logic       wr_n_s;
    logic [2:0] addr_s;
    logic [7:0] din_s;
    logic       err_n_s;
    logic       irq_lvl_s;
    logic       dack_s;

    assign sel_n_s   = bus_sync[13];
    assign rd_n_s    = bus_sync[12];
    assign wr_n_s    = bus_sync[11];
    assign addr_s    = bus_sync[10:8];
    assign din_s     = bus_sync[7:0];
    assign err_n_s   = pin_sync[2];
    assign irq_lvl_s = pin_sync[1];
    assign dack_s    = pin_sync[0];

    // ---------------------------------------------------------------
    // host strobe edges
    // ---------------------------------------------------------------
    logic rd_act;
    logic wr_act;
    logic rd_prev;
    logic wr_prev;
    logic err_prev;
    logic rd_start;
    logic wr_start;
    logic ours;

    // strobe active only with the window select
    assign rd_act   = ~sel_n_s & ~rd_n_s;
    assign wr_act   = ~sel_n_s & ~wr_n_s;
    assign rd_start = rd_act & ~rd_prev;
    assign wr_start = wr_act & ~wr_prev;

    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    ecx_pkg::ecx_mode_t next_mode;
    logic       mask;
    logic       dma_en;
    logic       service;
    logic [2:0] index;
    logic       next_mask;
    logic       next_dma_en;
    logic       next_service;
    logic [2:0] next_index;
    logic [7:0] next_ctrl0;
    logic [7:0] next_ctrl2;
    logic [7:0] next_ctrl4;
    logic [7:0] next_ppcfg;
    logic       next_irq;
    logic       fifo_evt;
    logic       err_evt;
    logic       wr_emc;
    logic       wr_idata;

    assign ours = addr_ours(addr_s, mode, ext_cfg_enable);
    assign wr_emc = wr_start & (addr_s == `ECX_OFF_EMC);
    assign wr_idata = wr_start & (addr_s == `ECX_OFF_IDATA) &
                      ext_cfg_enable; // see RULE19

    // FIFO and DMA interrupt events, thresholds are levels
    always_comb
    begin
        fifo_evt = 1'b0;
        if (dma_en)
            fifo_evt = dma_tc;                          // see RULE12
        else if (!dir_backward)
            fifo_evt = fifo_free_ge8;        // see RULE13 see RULE23
        else
            fifo_evt = fifo_avail_ge8;                  // see RULE13
    end

    // error edge while unmasked, or unmask with error asserted
    assign err_evt = (~mask & err_prev & ~err_n_s) |
                     (wr_emc & mask & ~din_s[`ECX_EMC_MASK] &
                      ~err_n_s);                        // see RULE15

    // next register values from host writes and hardware events
    always_comb
    begin
        next_mode    = mode;
        next_mask    = mask;
        next_dma_en  = dma_en;
        next_service = service;
        next_index   = index;
        next_ctrl0   = timeout_irq_control;
        next_ctrl2   = second_control_reg;
        next_ctrl4   = dma_fairness_control;
        next_ppcfg   = port_resource_config;
        next_irq     = 1'b0;
        if (wr_emc)
        begin
            next_mode   = ecx_pkg::ecx_mode_t'(din_s[7:5]); // see RULE16
            next_mask   = din_s[`ECX_EMC_MASK];
            next_dma_en = din_s[`ECX_EMC_DMAEN];
            next_service = din_s[`ECX_EMC_SERVICE];     // see RULE11
        end
        if (wr_start && (addr_s == `ECX_OFF_INDEX) && ext_cfg_enable)
            next_index = din_s[2:0];                    // see RULE18
        if (wr_idata)
        begin
            unique case (index)                         // see RULE20
                `ECX_IDX_CTRL0: next_ctrl0 = din_s;
                `ECX_IDX_CTRL2: next_ctrl2 = din_s;
                `ECX_IDX_CTRL4: next_ctrl4 = din_s;
                `ECX_IDX_PPCFG: next_ppcfg = din_s;    // see RULE4
                default:        next_ctrl0 = timeout_irq_control;
            endcase                                     // see RULE17
        end
        // armed event raises interrupt; set beats software clear
        if (fifo_evt && !service)
        begin
            next_service = 1'b1;                        // see RULE11
            next_irq     = 1'b1;
        end
        if (err_evt)
            next_irq = 1'b1;
    end

    // registers initialise on reset only, not on port activation
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            mode                 <= ecx_pkg::ECX_MODE_STD; // see RULE8
            mask                 <= `ECX_RST_MASK;
            dma_en               <= `ECX_RST_DMAEN;
            service              <= `ECX_RST_SERVICE;
            index                <= `ECX_RST_INDEX;
            timeout_irq_control  <= `ECX_RST_CTRL0;     // see RULE22
            second_control_reg   <= `ECX_RST_CTRL2;
            dma_fairness_control <= `ECX_RST_CTRL4;
            port_resource_config <= `ECX_RST_PPCFG;     // see RULE19
            ecp_irq              <= 1'b0;
        end
        else
        begin
            mode                 <= next_mode;
            mask                 <= next_mask;
            dma_en               <= next_dma_en;
            service              <= next_service;
            index                <= next_index;
            timeout_irq_control  <= next_ctrl0;
            second_control_reg   <= next_ctrl2;
            dma_fairness_control <= next_ctrl4;
            port_resource_config <= next_ppcfg;
            ecp_irq              <= next_irq;
        end
    end

    // ---------------------------------------------------------------
    // read multiplexer
    // ---------------------------------------------------------------
    logic [7:0] rd_value;
    logic [7:0] idata_value;

    // indirect data path, unsupported index reads zero
    always_comb
    begin
        idata_value = 8'h00;
        if (idx_valid(index))                           // see RULE17
        begin
            unique case (index)
                `ECX_IDX_CTRL0: idata_value = timeout_irq_control;
                `ECX_IDX_CTRL2: idata_value = second_control_reg;
                `ECX_IDX_CTRL4: idata_value = dma_fairness_control;
                default:        idata_value = port_resource_config;
            endcase                                     // see RULE20
        end
    end

    // value of the addressed register, sampled live
    always_comb
    begin
        rd_value = 8'h00;
        unique case (addr_s)
            `ECX_OFF_CAPA:
                rd_value = {`ECX_CAPA_HI,
                            port_resource_config[`ECX_PPCFG_CAPB],
                            `ECX_CAPA_LO};      // see RULE1 see RULE2
            `ECX_OFF_RSRC:
                rd_value = {1'b0, irq_lvl_s,            // see RULE7
                            port_resource_config[5:3],  // see RULE5 see RULE6
                            1'b0,                       // see RULE3
                            port_resource_config[1:0]}; // see RULE4
            `ECX_OFF_EMC:
                rd_value = {mode, mask, dma_en,
                            service & ~port_clk_frozen, // see RULE24
                            fifo_full | port_clk_frozen,
                            fifo_empty | port_clk_frozen}; // see RULE10
            `ECX_OFF_INDEX:
                rd_value = {5'h00, index};              // see RULE18
            `ECX_OFF_IDATA:
                rd_value = idata_value;
            `ECX_OFF_AUX:
                rd_value = {(mode == ecx_pkg::ECX_MODE_ECP) &
                            dir_backward & fifo_bottom_tag,
                            7'h00};                     // see RULE21
            default:
                rd_value = 8'h00;
        endcase
    end

    // ---------------------------------------------------------------
    // host read sequencer
    // ---------------------------------------------------------------
    ecx_pkg::ecx_rd_state_t rd_state;
    ecx_pkg::ecx_rd_state_t next_rd_state;
    logic [7:0]             next_data_out;

    // mode control reads wait one cycle so the flags settle
    always_comb
    begin
        next_rd_state = rd_state;
        next_data_out = io_data_out;
        unique case (rd_state)
            ecx_pkg::ECX_RD_IDLE:
                if (rd_start && ours)
                begin
                    if (addr_s == `ECX_OFF_EMC)
                        next_rd_state = ecx_pkg::ECX_RD_WAIT; // see RULE9
                    else
                    begin
                        next_rd_state = ecx_pkg::ECX_RD_DATA;
                        next_data_out = rd_value;
                    end
                end
            ecx_pkg::ECX_RD_WAIT:
            begin
                next_rd_state = ecx_pkg::ECX_RD_DATA;
                next_data_out = rd_value;
            end
            ecx_pkg::ECX_RD_DATA:
                if (!rd_act)
                    next_rd_state = ecx_pkg::ECX_RD_IDLE;
            default:
                next_rd_state = ecx_pkg::ECX_RD_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            rd_state    <= ecx_pkg::ECX_RD_IDLE;
            io_data_out <= 8'h00;
            rd_prev     <= 1'b0;
            wr_prev     <= 1'b0;
            err_prev    <= 1'b1;
        end
        else
        begin
            rd_state    <= next_rd_state;
            io_data_out <= next_data_out;
            rd_prev     <= rd_act;
            wr_prev     <= wr_act;
            err_prev    <= err_n_s;
        end
    end

    // ---------------------------------------------------------------
    // pin drivers and control outputs
    // ---------------------------------------------------------------

    // data bus driven once read data is latched
    assign io_data_oe_n = ~((rd_state == ecx_pkg::ECX_RD_DATA) & rd_act);

    // open-drain ready: pulled low while the read is stretched
    assign iochrdy_out  = 1'b0;
    assign iochrdy_oe_n = ~(rd_state == ecx_pkg::ECX_RD_WAIT); // see RULE9

    // DMA request floats when disabled, starts once service clears
    assign dma_req_oe_n = ~dma_en;                      // see RULE14
    assign dma_req_out  = dma_en & ~service & dma_req_raw;
    assign dma_ack_eff  = dma_en & dack_s;              // see RULE14

    // time-out interrupt enable
    assign epp_timeout_irq_en =
        timeout_irq_control[`ECX_CTRL0_TOEN];           // see RULE22

endmodule // ecx_regs

`default_nettype wire

// *** shared/ecx_map.svh ***
// register offsets, field positions, reset values and synchroniser width
`ifndef ECX_MAP_SVH
`define ECX_MAP_SVH

// ---------------------------------------------------------------
// host offsets inside the extended window (low three address bits)
// ---------------------------------------------------------------
`define ECX_OFF_CAPA     3'h0
`define ECX_OFF_RSRC     3'h1
`define ECX_OFF_EMC      3'h2
`define ECX_OFF_INDEX    3'h3
`define ECX_OFF_IDATA    3'h4
`define ECX_OFF_AUX      3'h5

// ---------------------------------------------------------------
// second-level offsets behind the index register
// ---------------------------------------------------------------
`define ECX_IDX_CTRL0    3'h0
`define ECX_IDX_CTRL2    3'h2
`define ECX_IDX_CTRL4    3'h4
`define ECX_IDX_PPCFG    3'h5

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ECX_RST_CTRL0    8'h00
`define ECX_RST_CTRL2    8'h00
`define ECX_RST_CTRL4    8'h07
`define ECX_RST_PPCFG    8'h00
`define ECX_RST_MASK     1'h1
`define ECX_RST_DMAEN    1'h0
`define ECX_RST_SERVICE  1'h1
`define ECX_RST_INDEX    3'h0

// ---------------------------------------------------------------
// fixed fields and field positions
// ---------------------------------------------------------------
`define ECX_CAPA_LO      3'h4
`define ECX_CAPA_HI      4'h1
`define ECX_PPCFG_CAPB   7
`define ECX_EMC_EMPTY    0
`define ECX_EMC_FULL     1
`define ECX_EMC_SERVICE  2
`define ECX_EMC_DMAEN    3
`define ECX_EMC_MASK     4
`define ECX_CTRL0_TOEN   0
`define ECX_AUX_TAG      7

// ---------------------------------------------------------------
// pin synchroniser width: sel, rd, wr, addr[2:0], data[7:0]
// ---------------------------------------------------------------
`define ECX_BUS_SYNC_W   14

`endif

// *** shared/ecx_pkg.sv ***
// types shared by the extended register bank
package ecx_pkg;

    // mode select field of the extended mode control register
    typedef enum logic [2:0] {
        ECX_MODE_STD    = 3'h0,
        ECX_MODE_BIDIR  = 3'h1,
        ECX_MODE_PFIFO  = 3'h2,
        ECX_MODE_ECP    = 3'h3,
        ECX_MODE_EPP    = 3'h4,
        ECX_MODE_RSVD   = 3'h5,
        ECX_MODE_TEST   = 3'h6,
        ECX_MODE_CFG    = 3'h7
    } ecx_mode_t;

    // host read sequencer: idle, stretch one cycle, data presented
    typedef enum logic [2:0] {
        ECX_RD_IDLE  = 3'b001,
        ECX_RD_WAIT  = 3'b010,
        ECX_RD_DATA  = 3'b100
    } ecx_rd_state_t;

endpackage

// *** tb/ecx_regs_properties.sv ***
// concurrent checks on the ports of the extended register bank
`timescale 1ns/1ps
`default_nettype none
module ecx_regs_properties (
    input wire logic               ref_clk,
    input wire logic               rstn,
    input wire logic               io_sel_n,
    input wire logic               io_rd_n,
    input wire logic [2:0]         io_addr,
    input wire logic               io_data_oe_n,
    input wire logic               iochrdy_out,
    input wire logic               iochrdy_oe_n,
    input wire logic               dma_tc,
    input wire logic               dma_req_out,
    input wire logic               dma_req_oe_n,
    input wire logic               dma_ack_eff,
    input wire logic               ecp_irq,
    input wire ecx_pkg::ecx_mode_t mode,
    input wire logic               epp_timeout_irq_en,
    input wire logic [7:0]         timeout_irq_control,
    input wire logic [7:0]         second_control_reg,
    input wire logic [7:0]         dma_fairness_control,
    input wire logic [7:0]         port_resource_config
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // ---------------------------------------------------------------
    // assertions and cover points
    // ---------------------------------------------------------------
    chk_reset_values: assert property (
        $rose(rstn) |-> mode == ecx_pkg::ECX_MODE_STD
        && timeout_irq_control == 8'h00 && second_control_reg == 8'h00
        && dma_fairness_control == 8'h07 && port_resource_config == 8'h00)
        else $error("register reset value wrong");
    chk_epp_enable: assert property (
        epp_timeout_irq_en == timeout_irq_control[0])
        else $error("time-out enable differs from control bit");
    chk_stretch_once: assert property (
        $fell(iochrdy_oe_n) |=> iochrdy_oe_n && !io_data_oe_n)
        else $error("stretch not one cycle before data");
    chk_stretch_cause: assert property (
        $fell(iochrdy_oe_n) |-> !io_sel_n && !io_rd_n && io_addr == 3'h2)
        else $error("stretch outside a mode control read");
    chk_ready_level: assert property (
        iochrdy_out == 1'b0)
        else $error("ready line not pulled low");
    chk_read_release: assert property (
        $rose(io_rd_n) |-> ##[1:3] io_data_oe_n)
        else $error("data bus held after read");
    chk_float_ack: assert property (
        dma_req_oe_n |-> !dma_ack_eff && !dma_req_out)
        else $error("acknowledge used while request floats");
    chk_tc_service: assert property (
        dma_tc && dma_req_out |=> ecp_irq && !dma_req_out)
        else $error("terminal count did not interrupt");
    chk_irq_pulse: assert property (
        ecp_irq |=> !ecp_irq)
        else $error("interrupt pulse too long");
    cov_irq: cover property (ecp_irq);
    cov_stretch: cover property ($fell(iochrdy_oe_n));
    cov_ack: cover property (dma_ack_eff);
endmodule // ecx_regs_properties
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench of the extended register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0;
    logic rstn, io_sel_n, io_rd_n, io_wr_n, err_n, irq_line_level;
    logic dma_ack_in, fifo_empty, fifo_full, fifo_free_ge8, fifo_avail_ge8;
    logic fifo_bottom_tag, dma_req_raw, dma_tc, dir_backward;
    logic port_clk_frozen, ext_cfg_enable, stretched;
    logic [2:0] io_addr;
    logic [7:0] io_data_in, io_data_out, timeout_irq_control;
    logic [7:0] second_control_reg, dma_fairness_control, port_resource_config;
    logic io_data_oe_n, iochrdy_out, iochrdy_oe_n, dma_req_out, dma_req_oe_n;
    logic ecp_irq, dma_ack_eff, epp_timeout_irq_en;
    ecx_pkg::ecx_mode_t mode;
    int error_cnt = 0;
    int n_compared = 0;
    int irq_cnt = 0;
    ecx_regs dut (.*);
    // clock and event counters
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        if (ecp_irq === 1'b1) irq_cnt++;
        if (iochrdy_oe_n === 1'b0) stretched = 1'b1;
    end
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic results;
        if (error_cnt == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
        io_addr = a;
        io_data_in = d;
        io_sel_n = 1'b0;
        io_wr_n = 1'b0;
        cyc(6);
        io_sel_n = 1'b1;
        io_wr_n = 1'b1;
        cyc(4);
    endtask
    // read one offset; 8'hZZ stands for an undriven bus
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp,
                          input string nm);
        logic [7:0] d;
        d = 8'hZZ;
        stretched = 1'b0;
        io_addr = a;
        io_sel_n = 1'b0;
        io_rd_n = 1'b0;
        for (int n = 0; n < 10 && io_data_oe_n !== 1'b0; n++) cyc(1);
        if (io_data_oe_n === 1'b0) d = io_data_out;
        cyc(2);
        io_sel_n = 1'b1;
        io_rd_n = 1'b1;
        cyc(5);
        chk(nm, d, exp);
        if (d !== 8'hZZ)
            chk("stretch", {7'h0, stretched}, 8'(a == 3'h2));
        if (d === 8'hZZ && exp !== 8'hZZ) results();
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        chk("fairness", dma_fairness_control, 8'h07);
        chk("mode", {5'h0, mode}, 8'h00);
        chk("dma oe", {7'h0, dma_req_oe_n}, 8'h01);
        rd_chk(3'h2, 8'h15, "emc reset");
        rd_chk(3'h3, 8'hZZ, "index off");
        rd_chk(3'h0, 8'hZZ, "capa off");
        fifo_empty = 1'b0;
        fifo_full = 1'b1;
        bus_wr(3'h2, 8'h17);
        rd_chk(3'h2, 8'h16, "emc flags");
        fifo_full = 1'b0;
        port_clk_frozen = 1'b1;
        rd_chk(3'h2, 8'h13, "emc frozen");
        port_clk_frozen = 1'b0;
        rd_chk(3'h2, 8'h14, "emc thawed");
    endtask
    task automatic t_indirect;
        logic [7:0] v;
        ext_cfg_enable = 1'b1;
        bus_wr(3'h3, 8'hFD);
        rd_chk(3'h3, 8'h05, "index");
        for (int i = 0; i < 8; i++)
        begin
            v = 8'hE1 ^ {i[2:0], 5'h0};
            bus_wr(3'h3, {5'h0, i[2:0]});
            bus_wr(3'h4, v);
            rd_chk(3'h4, (i inside {0, 2, 4, 5}) ? v : 8'h00,
                   "idata");
        end
        chk("ctrl0", timeout_irq_control, 8'hE1);
        chk("ctrl2", second_control_reg, 8'hA1);
        chk("ctrl4", dma_fairness_control, 8'h61);
        chk("ppcfg", port_resource_config, 8'h41);
        chk("epp en", {7'h0, epp_timeout_irq_en}, 8'h01);
    endtask
    task automatic t_config;
        logic [2:0] c;
        for (int m = 0; m < 8; m++)
        begin
            bus_wr(3'h2, {m[2:0], 5'h14});
            chk("mode", {5'h0, mode}, {5'h0, m[2:0]});
        end
        bus_wr(3'h3, 8'h05);
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:0];
            irq_line_level = c[0];
            bus_wr(3'h4, {2'h2, c, 1'b0, c[1:0]});
            bus_wr(3'h1, 8'hFF);
            rd_chk(3'h1, {1'b0, c[0], c, 1'b0, c[1:0]}, "rsrc");
        end
        bus_wr(3'h0, 8'h00);
        rd_chk(3'h0, 8'h1C, "capa");
        bus_wr(3'h4, 8'h00);
        rd_chk(3'h0, 8'h14, "capa low");
    endtask
    task automatic t_irq;
        int n;
        n = irq_cnt;
        fifo_free_ge8 = 1'b1;
        dir_backward = 1'b0;
        bus_wr(3'h2, 8'h10);
        rd_chk(3'h2, 8'h14, "svc set");
        fifo_free_ge8 = 1'b0;
        dir_backward = 1'b1;
        fifo_avail_ge8 = 1'b1;
        bus_wr(3'h2, 8'h10);
        chk("fifo irqs", 8'(irq_cnt - n), 8'h02);
        fifo_avail_ge8 = 1'b0;
        dma_req_raw = 1'b1;
        dma_ack_in = 1'b1;
        bus_wr(3'h2, 8'h18);
        chk("dma on", {5'h0, dma_req_oe_n, dma_req_out, dma_ack_eff},
            8'h03);
        dma_tc = 1'b1;
        cyc(1);
        dma_tc = 1'b0;
        cyc(2);
        chk("tc", {7'h0, dma_req_out}, 8'h00);
        chk("tc irqs", 8'(irq_cnt - n), 8'h03);
        bus_wr(3'h2, 8'h04);
        chk("dma off", {6'h0, dma_req_oe_n, dma_ack_eff}, 8'h02);
        err_n = 1'b0;
        cyc(5);
        bus_wr(3'h2, 8'h14);
        bus_wr(3'h2, 8'h04);
        bus_wr(3'h2, 8'h14);
        err_n = 1'b1;
        cyc(4);
        err_n = 1'b0;
        cyc(5);
        chk("err irqs", 8'(irq_cnt - n), 8'h05);
    endtask
    task automatic t_aux;
        bus_wr(3'h2, 8'h74);
        fifo_bottom_tag = 1'b1;
        rd_chk(3'h5, 8'h80, "tag set");
        fifo_bottom_tag = 1'b0;
        bus_wr(3'h5, 8'hFF);
        rd_chk(3'h5, 8'h00, "tag clear");
        rstn = 1'b0;
        cyc(3);
        rstn = 1'b1;
        cyc(1);
        chk("rearm ctrl4", dma_fairness_control, 8'h07);
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        {rstn, io_rd_n, io_wr_n, io_sel_n, err_n} = 5'h0F;
        {io_addr, io_data_in, irq_line_level, dma_ack_in} = 13'h0;
        {fifo_empty, fifo_full, fifo_free_ge8, fifo_avail_ge8} = 4'h8;
        {fifo_bottom_tag, dma_req_raw, dma_tc, dir_backward} = 4'h0;
        {port_clk_frozen, ext_cfg_enable, stretched} = 3'h0;
        cyc(5);
        rstn = 1'b1;
        cyc(2);
        t_reset();
        t_indirect();
        t_config();
        t_irq();
        t_aux();
        results();
    end
endmodule // tb_top
bind ecx_regs ecx_regs_properties u_chk (.*);
`default_nettype wire
